// >>> rtl/das_defs.svh
`ifndef DAS_DEFS_SVH
`define DAS_DEFS_SVH
// Register addresses (index on the plain register port)
`define ADDR_DIN 4'h0
`define ADDR_DOUT 4'h1
`define ADDR_DAC1 4'h2
`define ADDR_DAC2 4'h3
`define ADDR_DAMODE 4'h4
`define ADDR_CHAN 4'h5
`define ADDR_RANGE 4'h6
`define ADDR_ADMODE 4'h7
`define ADDR_SCAN 4'h8
`define ADDR_FIFOEN 4'h9
`define ADDR_FIFODATA 4'ha
`define ADDR_FIFOSTAT 4'hb
`define ADDR_STATUS 4'hc
`define ADDR_MASK 4'hd
`define ADDR_ADDATA 4'he
`define ADDR_SOFTTRIG 4'hf
// Field positions
`define DAMODE_TWOS_BIT 0
`define DAMODE_BUF_BIT 1
`define ADMODE_TRIG_LSB 0
`define ADMODE_XFER_LSB 2
// Reset values
`define RST_DAMODE 2'h2
`define RST_CHAN 4'h0
`define RST_RANGE 2'h0
`define RST_ADMODE 4'h0
`define RST_DAC 12'h000
// Interrupt status bit positions
`define IRQ_EXT_BIT 0
`define IRQ_EOC_BIT 1
`define IRQ_PACER_BIT 2
`define IRQ_HALF_BIT 3
`endif

// >>> rtl/das_pkg.sv
package das_pkg;
    typedef enum logic [1:0] {
        out_immediate_binary = 2'h0,
        out_immediate_twos = 2'h1,
        out_buffered_binary = 2'h2,
        out_buffered_twos = 2'h3
    } da_mode_t;
    typedef enum logic [1:0] {
        trig_software = 2'h0,
        trig_pacer = 2'h1,
        trig_external = 2'h2
    } trig_src_t;
    typedef enum logic [1:0] {
        gain_x1 = 2'h0,
        gain_x2 = 2'h1,
        gain_x4 = 2'h2,
        gain_x8 = 2'h3
    } gain_t;
    typedef enum logic [1:0] {
        irq_from_ext_trigger = 2'h0,
        irq_from_conversion_done = 2'h1,
        irq_from_pacer = 2'h2,
        irq_from_buffer_half = 2'h3
    } irq_src_t;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_convert = 2'b01,
        st_done = 2'b11
    } conv_state_t;
endpackage

// >>> rtl/das_card_control_logic.sv
// Notes on behaviour
// RL1: Digital inputs read as one 16-bit word.
// RL2: Digital outputs hold last written value.
// RL3: Four output modes: update and coding.
// RL4: Two's complement flips the top bit.
// RL5: Two 12-bit analog output channels.
// RL6: Buffered mode updates both on channel two.
// RL7: Reset selects buffered mode, outputs zero.
// RL8: Host writes channel number zero to fifteen.
// RL9: Channel zero selected after reset.
// RL10: Range register selects gain 1,2,4,8.
// RL11: Mode register: trigger and transfer; reset soft/poll.
// RL12: Auto-scan counts down, reloads at zero.
// RL13: Without auto-scan, one channel always.
// RL14: Enabled buffer stores results, 1024 words.
// RL15: Four interrupt sources: ext, done, pacer, half.
// RL16: Request stays pending until host clears.
// RL17: Channel advances when conversion completes.
// RL18: Host programs settings before triggering.
`timescale 1ns/1ps
`include "das_defs.svh"
module das_card_control_logic #(
    parameter int DEPTH_LOG2 = 10,
    parameter int SAMPLE_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [15:0] i_din,
    output logic [15:0] o_dout,
    output logic [11:0] o_dac1_code,
    output logic [11:0] o_dac2_code,
    input wire logic i_ext_trig,
    input wire logic i_pacer_tick,
    output logic o_adc_start,
    input wire logic i_adc_done,
    input wire logic [SAMPLE_W-1:0] i_adc_data,
    output logic [3:0] o_adc_chan,
    output das_pkg::gain_t o_adc_gain,
    output logic o_buffer_half_full,
    output logic o_irq
);
    import das_pkg::*;

    localparam int DEPTH = 1 << DEPTH_LOG2;

    // Pin synchronisers: first stage read only by second
    logic [15:0] din_s1_ff, din_s2_ff;
    logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [SAMPLE_W-1:0] adc_s1_ff, adc_s2_ff;
    always_ff @(posedge i_clk_sys) begin
        din_s1_ff <= i_din;
        din_s2_ff <= din_s1_ff;
        adc_s1_ff <= i_adc_data; // Result settles well before done
        adc_s2_ff <= adc_s1_ff;
        pin_s1_ff <= {i_adc_done, i_pacer_tick, i_ext_trig};
        pin_s2_ff <= pin_s1_ff;
        pin_s3_ff <= pin_s2_ff;
    end
    // Rising edges taken from second and third stages
    wire ext_edge = pin_s2_ff[0] & ~pin_s3_ff[0];
    wire pacer_edge = pin_s2_ff[1] & ~pin_s3_ff[1];
    wire done_edge = pin_s2_ff[2] & ~pin_s3_ff[2];

    // Write and read decode
    wire wr_dout = i_wr && i_addr == `ADDR_DOUT;
    wire wr_dac1 = i_wr && i_addr == `ADDR_DAC1;
    wire wr_dac2 = i_wr && i_addr == `ADDR_DAC2;
    wire wr_damode = i_wr && i_addr == `ADDR_DAMODE;
    wire wr_chan = i_wr && i_addr == `ADDR_CHAN;
    wire wr_range = i_wr && i_addr == `ADDR_RANGE;
    wire wr_admode = i_wr && i_addr == `ADDR_ADMODE;
    wire wr_scan = i_wr && i_addr == `ADDR_SCAN;
    wire wr_fifoen = i_wr && i_addr == `ADDR_FIFOEN;
    wire wr_mask = i_wr && i_addr == `ADDR_MASK;
    wire wr_soft = i_wr && i_addr == `ADDR_SOFTTRIG;
    wire rd_status = i_rd && i_addr == `ADDR_STATUS;
    wire rd_fifo = i_rd && i_addr == `ADDR_FIFODATA;

    // Two's complement input is the binary code with its top bit flipped
    function automatic logic [11:0] to_binary(input logic [11:0] code,
                                              input logic twos);
        to_binary = {code[11] ^ twos, code[10:0]}; // RL4
    endfunction

    // Control registers
    logic [15:0] dout_ff;
    da_mode_t damode_ff;
    logic [11:0] hold1_ff, dac1_ff, dac2_ff;
    logic [3:0] chan_ff;
    gain_t range_ff;
    logic [3:0] admode_ff;
    logic scan_ff, fifoen_ff;
    logic [3:0] mask_ff;
    wire twos = damode_ff[`DAMODE_TWOS_BIT]; // RL3
    wire buffered = damode_ff[`DAMODE_BUF_BIT]; // RL3
    wire [11:0] wcode = to_binary(i_wdata[11:0], twos);

    // Host settings; digital out holds until rewritten
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            dout_ff <= 16'h0000;
            damode_ff <= da_mode_t'(`RST_DAMODE); // RL7
            chan_ff <= `RST_CHAN; // RL9
            range_ff <= gain_t'(`RST_RANGE); // RL10
            admode_ff <= `RST_ADMODE; // RL11
            scan_ff <= 1'b0;
            fifoen_ff <= 1'b0;
            mask_ff <= 4'h0;
        end else begin
            if (wr_dout) dout_ff <= i_wdata; // RL2
            if (wr_damode) damode_ff <= da_mode_t'(i_wdata[1:0]); // RL3
            if (wr_chan) chan_ff <= i_wdata[3:0]; // RL8
            if (wr_range) range_ff <= gain_t'(i_wdata[1:0]); // RL10
            if (wr_admode) admode_ff <= i_wdata[3:0]; // RL11
            if (wr_scan) scan_ff <= i_wdata[0];
            if (wr_fifoen) fifoen_ff <= i_wdata[0];
            if (wr_mask) mask_ff <= i_wdata[3:0];
        end
    end

    chk_dout_hold: assert property (@(posedge i_clk_sys) // RL2
        disable iff (i_sys_rst) !wr_dout |=> $stable(o_dout))
        else $error("digital output changed unwritten");

    // Converter codes: immediate per channel, or both on channel two
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            hold1_ff <= `RST_DAC;
            dac1_ff <= `RST_DAC; // RL7
            dac2_ff <= `RST_DAC;
        end else begin
            if (wr_dac1) hold1_ff <= wcode; // RL5
            if (wr_dac1 && !buffered) dac1_ff <= wcode; // RL3
            if (wr_dac2) dac2_ff <= wcode; // RL5
            if (wr_dac2 && buffered) dac1_ff <= hold1_ff; // RL6
        end
    end
    // Hazard: a hold from buffered mode is not flushed on mode change
    chk_dac_buffered: assert property (@(posedge i_clk_sys) // RL6
        disable iff (i_sys_rst) wr_dac1 && buffered |=> $stable(dac1_ff))
        else $error("dac1 moved before channel two write");
    chk_dac_pair: assert property (@(posedge i_clk_sys) // RL6
        disable iff (i_sys_rst) wr_dac2 && buffered |=>
        dac1_ff == $past(hold1_ff))
        else $error("dac1 not loaded with channel two");
    chk_twos_map: assert property (@(posedge i_clk_sys) // RL4
        disable iff (i_sys_rst) wr_dac2 && twos |=>
        dac2_ff == {~$past(i_wdata[11]), $past(i_wdata[10:0])})
        else $error("two's complement mapping wrong");

    // Trigger source select
    wire [1:0] trig_sel = admode_ff[`ADMODE_TRIG_LSB +: 2];
    wire trig_go = (trig_sel == trig_software && wr_soft) ||
                   (trig_sel == trig_pacer && pacer_edge) ||
                   (trig_sel == trig_external && ext_edge);

    // Conversion sequencer; start is a one-cycle pulse
    conv_state_t state_ff, nxt_state;
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            st_idle: if (trig_go) nxt_state = st_convert;
            st_convert: if (done_edge) nxt_state = st_done;
            st_done: nxt_state = st_idle;
            default: nxt_state = st_idle;
        endcase
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) state_ff <= st_idle;
        else state_ff <= nxt_state;
    end
    wire conv_end = state_ff == st_convert && done_edge;
    chk_start_pulse: assert property (@(posedge i_clk_sys) // RL11
        disable iff (i_sys_rst) o_adc_start |=>
        state_ff == st_convert && !o_adc_start)
        else $error("start not a single pulse");

    // Scan counter moves at completion or on a channel write, otherwise stable through a conversion
    logic [3:0] scan_ch_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) scan_ch_ff <= `RST_CHAN; // RL9
        else if (wr_chan) scan_ch_ff <= i_wdata[3:0];
        else if (conv_end) begin // RL17
            if (!scan_ff || scan_ch_ff == 4'h0) scan_ch_ff <= chan_ff; // RL13
            else scan_ch_ff <= scan_ch_ff - 4'h1; // RL12
        end
    end

    chk_scan_down: assert property (@(posedge i_clk_sys) // RL12
        disable iff (i_sys_rst) conv_end && scan_ff && !wr_chan &&
        scan_ch_ff != 4'h0 |=> scan_ch_ff == $past(scan_ch_ff) - 4'h1)
        else $error("scan did not decrement");
    chk_scan_reload: assert property (@(posedge i_clk_sys) // RL12
        disable iff (i_sys_rst) conv_end && scan_ff && !wr_chan &&
        scan_ch_ff == 4'h0 |=> scan_ch_ff == $past(chan_ff))
        else $error("scan did not reload");
    chk_single_ch: assert property (@(posedge i_clk_sys) // RL13
        disable iff (i_sys_rst) !scan_ff && !wr_chan && conv_end |=>
        scan_ch_ff == chan_ff)
        else $error("single channel not kept");
    chk_ch_stable: assert property (@(posedge i_clk_sys) // RL17
        disable iff (i_sys_rst) state_ff == st_convert && !conv_end &&
        !wr_chan |=> $stable(o_adc_chan))
        else $error("channel moved mid conversion");

    // Sample buffer, 1024 words by default
    logic [SAMPLE_W-1:0] mem [DEPTH];
    logic [DEPTH_LOG2:0] wp_ff, rp_ff;
    logic [SAMPLE_W-1:0] last_ff, fifo_q_ff;
    wire [DEPTH_LOG2:0] level = wp_ff - rp_ff;
    wire full = level == DEPTH[DEPTH_LOG2:0];
    wire empty = level == '0;
    wire half = level >= DEPTH[DEPTH_LOG2+1:1];
    wire push = conv_end && fifoen_ff && !full; // RL14
    wire pop = rd_fifo && !empty;
    // Overflow drops new samples; older data stays in order
    always_ff @(posedge i_clk_sys) begin
        if (push) mem[wp_ff[DEPTH_LOG2-1:0]] <= adc_s2_ff; // RL14
        if (pop) fifo_q_ff <= mem[rp_ff[DEPTH_LOG2-1:0]];
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || (wr_fifoen && !i_wdata[0])) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) wp_ff <= wp_ff + 1'b1;
            if (pop) rp_ff <= rp_ff + 1'b1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) last_ff <= '0;
        else if (conv_end) last_ff <= adc_s2_ff;
    end
    chk_fifo_push: assert property (@(posedge i_clk_sys) // RL14
        disable iff (i_sys_rst) push && !pop && !wr_fifoen |=>
        level == $past(level) + 1'b1)
        else $error("sample not stored");

    // Sticky events; a new event wins over read-clear
    logic half_d_ff;
    logic [3:0] status_ff;
    wire [3:0] events = {half & ~half_d_ff, pacer_edge, conv_end,
                         ext_edge}; // RL15
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            status_ff <= 4'h0;
            half_d_ff <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            half_d_ff <= half;
            status_ff <= (rd_status ? 4'h0 : status_ff) | events; // RL16
            o_irq <= |(((rd_status ? 4'h0 : status_ff) | events)
                       & mask_ff); // RL16
        end
    end

    chk_irq_pending: assert property (@(posedge i_clk_sys) // RL16
        disable iff (i_sys_rst) status_ff[`IRQ_EOC_BIT] && !rd_status |=>
        status_ff[`IRQ_EOC_BIT])
        else $error("pending request lost");
    chk_irq_level: assert property (@(posedge i_clk_sys) // RL16
        disable iff (i_sys_rst) o_irq == |(status_ff & $past(mask_ff)))
        else $error("interrupt level disagrees with status");

    // Read mux; registered, answers the cycle after the strobe
    logic [15:0] rmux;
    logic fifo_rd_d_ff;
    always_comb begin
        rmux = 16'h0000;
        unique case (i_addr)
            `ADDR_DIN: rmux = din_s2_ff; // RL1
            `ADDR_DOUT: rmux = dout_ff;
            `ADDR_DAMODE: rmux = {14'h0000, damode_ff};
            `ADDR_CHAN: rmux = {12'h000, chan_ff};
            `ADDR_RANGE: rmux = {14'h0000, range_ff};
            `ADDR_ADMODE: rmux = {12'h000, admode_ff};
            `ADDR_SCAN: rmux = {15'h0000, scan_ff};
            `ADDR_FIFOEN: rmux = {15'h0000, fifoen_ff};
            `ADDR_FIFOSTAT: rmux = {2'b00, half, full, empty, 11'(level)};
            `ADDR_STATUS: rmux = {12'h000, status_ff};
            `ADDR_MASK: rmux = {12'h000, mask_ff};
            `ADDR_ADDATA: rmux = 16'(last_ff);
            default: rmux = 16'h0000;
        endcase
    end
    logic [15:0] rdata_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rdata_ff <= 16'h0000;
            fifo_rd_d_ff <= 1'b0;
        end else begin
            rdata_ff <= i_rd ? rmux : 16'h0000;
            fifo_rd_d_ff <= pop;
        end
    end
    assign o_rdata = fifo_rd_d_ff ? 16'(fifo_q_ff) : rdata_ff;

    assign o_dout = dout_ff;
    assign o_dac1_code = dac1_ff;
    assign o_dac2_code = dac2_ff;
    assign o_adc_start = state_ff == st_idle && trig_go;
    assign o_adc_chan = scan_ch_ff;
    assign o_adc_gain = range_ff;
    assign o_buffer_half_full = half;

endmodule

// >>> tb/adc_model.sv
`timescale 1ns/1ps
module adc_model #(
    parameter int LAT = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_start,
    input wire logic [3:0] i_chan,
    output logic o_done,
    output logic [15:0] o_data
);
    int cnt = 0;
    initial o_done = 1'b0;
    initial o_data = 16'h0000;
    // Result tagged with the channel; held while done is high, then scrambled as done falls
    always @(posedge i_clk_sys) begin
        if (i_start) begin
            cnt <= LAT;
            o_data <= 16'ha500 | {12'h000, i_chan};
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        o_done <= (cnt <= 6) && (cnt > 1);
        if (cnt == 1) begin
            o_data <= ~o_data;
        end
    end
endmodule

// >>> tb/test_das_card_control_logic.sv
`timescale 1ns/1ps
`include "das_defs.svh"
module test_das_card_control_logic;
    import das_pkg::*;
    logic i_clk_sys = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, i_din = 16'h0000, rd_v, rdata, dout;
    logic ext = 0, pacer = 0, adc_done, adc_start, half, irq;
    logic [15:0] adc_data;
    logic [11:0] dac1, dac2, e1, t;
    logic [3:0] chan;
    gain_t gain;
    int mismatches = 0, n_compared = 0, cyc = 0, n_start = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    // Start pulses seen; one per trigger expected
    always @(posedge i_clk_sys) begin
        if (adc_start === 1'b1) n_start <= n_start + 1;
    end
    das_card_control_logic #(.DEPTH_LOG2(4), .SAMPLE_W(16)) i_dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_din(i_din), .o_dout(dout), .o_dac1_code(dac1),
        .o_dac2_code(dac2), .i_ext_trig(ext), .i_pacer_tick(pacer),
        .o_adc_start(adc_start), .i_adc_done(adc_done),
        .i_adc_data(adc_data), .o_adc_chan(chan), .o_adc_gain(gain),
        .o_buffer_half_full(half), .o_irq(irq));
    adc_model i_adc (.i_clk_sys(i_clk_sys), .i_start(adc_start),
        .i_chan(chan), .o_done(adc_done), .o_data(adc_data));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 rd_v = rdata;
    endtask
    task automatic conv();
        wr(`ADDR_SOFTTRIG, 16'h0000);
        repeat (24) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic t_reset();
        chk(dout, 16'h0000);
        chk({dac1, dac2[11:8]}, 16'h0000);
        chk({4'h0, chan, 6'h00, gain}, 16'h0000);
        rd(`ADDR_DAMODE);
        chk(rd_v, 16'h0002);
        rd(`ADDR_ADMODE);
        chk(rd_v, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_dio();
        @(posedge i_clk_sys);
        i_din <= 16'hc3a5;
        repeat (4) @(posedge i_clk_sys);
        rd(`ADDR_DIN);
        chk(rd_v, 16'hc3a5);
        wr(`ADDR_DOUT, 16'h5a0f);
        repeat (5) @(posedge i_clk_sys);
        chk(dout, 16'h5a0f);
        $display("test dio done");
    endtask
    // Buffered modes must keep channel one until channel two is written
    task automatic t_dac();
        e1 = 12'h000;
        for (int m = 0; m < 4; m++) begin
            t = m[0] ? 12'h800 : 12'h000;
            wr(`ADDR_DAMODE, 16'(m));
            wr(`ADDR_DAC1, 16'h07ff);
            chk({4'h0, dac1}, {4'h0, m[1] ? e1 : 12'h7ff ^ t});
            wr(`ADDR_DAC2, 16'h0800);
            e1 = 12'h7ff ^ t;
            chk({4'h0, dac1}, {4'h0, e1});
            chk({4'h0, dac2}, {4'h0, 12'h800 ^ t});
        end
        $display("test dac done");
    endtask
    task automatic t_sel();
        for (int g = 0; g < 4; g++) begin
            wr(`ADDR_RANGE, 16'(g));
            chk({14'h0000, gain}, 16'(g));
        end
        wr(`ADDR_CHAN, 16'h000f);
        chk({12'h000, chan}, 16'h000f);
        rd(`ADDR_CHAN);
        chk(rd_v, 16'h000f);
        $display("test select done");
    endtask
    task automatic t_scan();
        logic [3:0] seq [4] = '{4'h1, 4'h0, 4'h2, 4'h1};
        int s0;
        wr(`ADDR_CHAN, 16'h0002);
        wr(`ADDR_SCAN, 16'h0001);
        s0 = n_start;
        foreach (seq[i]) begin
            conv();
            chk({12'h000, chan}, {12'h000, seq[i]});
        end
        chk(16'(n_start - s0), 16'h0004);
        wr(`ADDR_SCAN, 16'h0000);
        wr(`ADDR_CHAN, 16'h0005);
        conv();
        conv();
        chk({12'h000, chan}, 16'h0005);
        $display("test scan done");
    endtask
    task automatic t_buf();
        wr(`ADDR_FIFOEN, 16'h0001);
        wr(`ADDR_MASK, 16'h0002);
        rd(`ADDR_STATUS);
        conv();
        repeat (10) @(posedge i_clk_sys);
        chk({15'h0000, irq}, 16'h0001);
        rd(`ADDR_FIFOSTAT);
        chk(rd_v, 16'h0001);
        rd(`ADDR_FIFODATA);
        chk(rd_v, 16'ha505);
        rd(`ADDR_ADDATA);
        chk(rd_v, 16'ha505);
        rd(`ADDR_FIFOSTAT);
        chk(rd_v, 16'h0800);
        rd(`ADDR_STATUS);
        chk(rd_v, 16'h0002);
        @(posedge i_clk_sys);
        #1 chk({15'h0000, irq}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            chk({15'h0000, half}, 16'h0000);
            conv();
        end
        chk({15'h0000, half}, 16'h0001);
        rd(`ADDR_FIFOSTAT);
        chk(rd_v, 16'h2008);
        rd(`ADDR_STATUS);
        chk(rd_v, 16'h000a);
        wr(`ADDR_FIFOEN, 16'h0000);
        $display("test buffer done");
    endtask
    // Pacer and external trigger each start a conversion and flag it
    task automatic t_src();
        wr(`ADDR_MASK, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            wr(`ADDR_ADMODE, s ? 16'h0002 : 16'h0001);
            rd(`ADDR_STATUS);
            @(posedge i_clk_sys);
            {ext, pacer} <= s ? 2'b10 : 2'b01;
            repeat (3) @(posedge i_clk_sys);
            {ext, pacer} <= 2'b00;
            repeat (24) @(posedge i_clk_sys);
            rd(`ADDR_STATUS);
            chk(rd_v, s ? 16'h0003 : 16'h0006);
        end
        $display("test sources done");
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs well under the 6000 cycles at which this watchdog fails it
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        #1;
        t_reset();
        t_dio();
        t_dac();
        t_sel();
        t_scan();
        t_buf();
        t_src();
        conclude();
    end
endmodule
